// *** core/otp_prog.sv ***
`timescale 1ns/1ps
`default_nettype none
module otp_prog #(
	parameter int PULSE_CYC = otp_prog_pkg::PULSE_CYC,
	parameter int SETUP_CYC = otp_prog_pkg::SETUP_CYC,
	parameter int DV_CYC    = otp_prog_pkg::DATA_VALID_CYC,
	parameter logic [15:0] LAST_ADDR = 16'hFFFF
) (
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	input  wire logic        START,
	input  wire logic        ID_START,
	input  wire logic        ID_SEL,
	input  wire logic        LOAD_EN,
	input  wire logic [15:0] LOAD_ADDR,
	input  wire logic [7:0]  LOAD_DATA,
	input  wire logic [7:0]  BYTE_OUTPUTS_I,
	output logic      [15:0] ADDR,
	output logic      [7:0]  DATA_O,
	output logic             DATA_OE,
	output logic             CE_N,
	output logic             OE_N,
	output logic             VPP_HIGH,
	output logic             VCC_PROG,
	output logic             ID_HIGH_VOLTAGE_LINE,
	output logic             BUSY,
	output logic             DONE,
	output logic             FAIL,
	output logic      [7:0]  ID_BYTE
);
	typedef struct packed {
		otp_prog_pkg::phase_e ph;
		logic [31:0] cnt;
		logic [15:0] addr;
		logic [3:0]  retry;
		logic        pass2;
		logic        vcc;
		logic        vpp;
		logic        ce_n;
		logic        oe_n;
		logic        doe;
		logic        idhv;
		logic        busy;
		logic        done;
		logic        fail;
		logic [7:0]  idb;
		logic [7:0]  din_m;
		logic [7:0]  din;
		logic [31:0] pw;
	} st_s;

	st_s s_q, s_d;
	otp_src_if src ();
	assign src.addr = s_d.addr;

	otp_src_mem #(.AW(16)) u_mem (
		.clk     (REF_CLK),
		.wr_en   (LOAD_EN),
		.wr_addr (LOAD_ADDR),
		.wr_data (LOAD_DATA),
		.rd      (src)
	);

	// Sequencer next state; the device data pins pass two flops before use.
	always_comb begin
		s_d = s_q;
		s_d.cnt = s_q.cnt + 32'd1;
		s_d.din_m = BYTE_OUTPUTS_I;
		s_d.din = s_q.din_m;
		s_d.pw = (!s_q.ce_n && s_q.doe) ? s_q.pw + 32'd1 : 32'd0;
		case (s_q.ph)
			otp_prog_pkg::ST_IDLE: begin
				s_d.cnt = 32'd0;
				s_d.done = 1'b0;
				if (START) begin
					s_d.addr = otp_prog_pkg::ADDR_FIRST;
					s_d.fail = 1'b0;
					s_d.busy = 1'b1;
					s_d.pass2 = 1'b0;
					s_d.vcc = 1'b1;
					s_d.ph = otp_prog_pkg::ST_RAMP;
				end else if (ID_START) begin
					s_d.addr = ID_SEL ? otp_prog_pkg::ID_PART_ADDR
						: otp_prog_pkg::ID_MAKER_ADDR;
					s_d.idhv = 1'b1;
					s_d.busy = 1'b1;
					s_d.ce_n = 1'b0;
					s_d.oe_n = 1'b0;
					s_d.ph = otp_prog_pkg::ST_ID_READ;
				end
			end
			otp_prog_pkg::ST_RAMP: begin
				// Supply up first, high voltage after setup time.
				if (s_q.cnt == 32'(SETUP_CYC)) begin
					s_d.vpp = 1'b1;
				end
				if (s_q.cnt == 32'(2 * SETUP_CYC)) begin
					s_d.cnt = 32'd0;
					s_d.doe = 1'b1;
					s_d.ph = otp_prog_pkg::ST_PGM_SET;
				end
			end
			otp_prog_pkg::ST_PGM_SET: begin
				// Address and data settle before the pulse.
				if (s_q.cnt == 32'(SETUP_CYC)) begin
					s_d.cnt = 32'd0;
					s_d.ce_n = 1'b0;
					s_d.ph = s_q.pass2 ? otp_prog_pkg::ST_RETRY_PULSE
						: otp_prog_pkg::ST_PGM_PULSE;
				end
			end
			otp_prog_pkg::ST_PGM_PULSE: begin
				// Blind first pass, one nominal pulse per address.
				if (s_q.cnt == 32'(PULSE_CYC - 1)) begin
					s_d.ce_n = 1'b1;
					s_d.cnt = 32'd0;
					if (s_q.addr == LAST_ADDR) begin
						s_d.addr = otp_prog_pkg::ADDR_FIRST;
						s_d.pass2 = 1'b1;
						s_d.retry = otp_prog_pkg::RETRY_RESET;
						s_d.doe = 1'b0;
						s_d.ph = otp_prog_pkg::ST_VFY_SET;
					end else begin
						s_d.addr = s_q.addr + 16'd1;
						s_d.ph = otp_prog_pkg::ST_PGM_SET;
					end
				end
			end
			otp_prog_pkg::ST_VFY_SET: begin
				// Release bus, wait hold time, then read with CE low.
				if (s_q.cnt == 32'(SETUP_CYC)) begin
					s_d.cnt = 32'd0;
					s_d.ce_n = 1'b0;
					s_d.ph = otp_prog_pkg::ST_VFY_READ;
				end
			end
			otp_prog_pkg::ST_VFY_READ: begin
				if (s_q.cnt == 32'(DV_CYC + 3)) begin
					s_d.ce_n = 1'b1;
					s_d.cnt = 32'd0;
					if (s_q.din == src.data) begin
						s_d.retry = otp_prog_pkg::RETRY_RESET;
						if (s_q.addr == LAST_ADDR) begin
							s_d.vpp = 1'b0;
							s_d.ph = otp_prog_pkg::ST_RAMP_DOWN;
						end else begin
							s_d.addr = s_q.addr + 16'd1;
							s_d.ph = otp_prog_pkg::ST_VFY_SET;
						end
					end else if (s_q.retry == 4'(otp_prog_pkg::MAX_RETRIES)) begin
						s_d.fail = 1'b1;
						s_d.vpp = 1'b0;
						s_d.ph = otp_prog_pkg::ST_RAMP_DOWN;
					end else begin
						s_d.retry = s_q.retry + 4'd1;
						s_d.doe = 1'b1;
						s_d.ph = otp_prog_pkg::ST_PGM_SET;
					end
				end
			end
			otp_prog_pkg::ST_RETRY_PULSE: begin
				if (s_q.cnt == 32'(PULSE_CYC - 1)) begin
					s_d.ce_n = 1'b1;
					s_d.doe = 1'b0;
					s_d.cnt = 32'd0;
					s_d.ph = otp_prog_pkg::ST_VFY_SET;
				end
			end
			otp_prog_pkg::ST_RAMP_DOWN: begin
				// High voltage off first, supply drops after.
				if (s_q.cnt == 32'(SETUP_CYC)) begin
					s_d.vcc = 1'b0;
					s_d.oe_n = 1'b0;
				end
				if (s_q.cnt == 32'(2 * SETUP_CYC)) begin
					s_d.cnt = 32'd0;
					s_d.addr = otp_prog_pkg::ADDR_FIRST;
					s_d.ce_n = 1'b0;
					s_d.ph = s_q.fail ? otp_prog_pkg::ST_DONE
						: otp_prog_pkg::ST_RB_READ;
				end
			end
			otp_prog_pkg::ST_RB_READ: begin
				// Normal-supply read-back of every byte.
				if (s_q.cnt == 32'(DV_CYC + 3)) begin
					s_d.cnt = 32'd0;
					if (s_q.din != src.data) begin
						s_d.fail = 1'b1;
					end
					if (s_q.addr == LAST_ADDR) begin
						s_d.ph = otp_prog_pkg::ST_DONE;
					end else begin
						s_d.addr = s_q.addr + 16'd1;
					end
				end
			end
			otp_prog_pkg::ST_ID_READ: begin
				if (s_q.cnt == 32'(SETUP_CYC + DV_CYC)) begin
					s_d.idb = s_q.din;
					s_d.ph = otp_prog_pkg::ST_DONE;
				end
			end
			otp_prog_pkg::ST_DONE: begin
				s_d.ce_n = 1'b1;
				s_d.oe_n = 1'b1;
				s_d.idhv = 1'b0;
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.ph = otp_prog_pkg::ST_IDLE;
			end
			default: s_d.ph = otp_prog_pkg::ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			s_q <= '0;
			s_q.ce_n <= 1'b1;
			s_q.oe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign ADDR = s_q.addr;
	assign DATA_O = src.data;
	assign DATA_OE = s_q.doe;
	assign CE_N = s_q.ce_n;
	assign OE_N = s_q.oe_n;
	assign VPP_HIGH = s_q.vpp;
	assign VCC_PROG = s_q.vcc;
	assign ID_HIGH_VOLTAGE_LINE = s_q.idhv;
	assign BUSY = s_q.busy;
	assign DONE = s_q.done;
	assign FAIL = s_q.fail;
	assign ID_BYTE = s_q.idb;

	// Every check below runs on the reference clock and rests in reset.
	default clocking dclk @(posedge REF_CLK);
	endclocking
	default disable iff (!RSTN);

	// Pulse width, voltages and supply order around every pulse and read.
	property p_pulse_len;
		($fell(CE_N) && VPP_HIGH && DATA_OE) |-> !CE_N [*8];
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("short pulse");
	property p_pulse_width;
		($rose(CE_N) && s_q.pw != 32'd0) |->
			(s_q.pw >= 32'(PULSE_CYC * otp_prog_pkg::PULSE_MIN_PCT / 100)
			&& s_q.pw <= 32'(PULSE_CYC * otp_prog_pkg::PULSE_MAX_PCT / 100));
	endproperty
	a_pulse_width: assert property (p_pulse_width)
		else $error("pulse width");
	property p_volt_first;
		(!CE_N && DATA_OE) |-> (VPP_HIGH && VCC_PROG);
	endproperty
	a_volt_first: assert property (p_volt_first) else $error("pulse w/o vpp");
	property p_supply_order;
		VPP_HIGH |-> VCC_PROG;
	endproperty
	a_supply_order: assert property (p_supply_order) else $error("vcc order");
	property p_rb_low;
		(s_q.ph == otp_prog_pkg::ST_RB_READ) |-> (!VPP_HIGH && !VCC_PROG);
	endproperty
	a_rb_low: assert property (p_rb_low) else $error("rb voltage");
	property p_id_mode;
		ID_HIGH_VOLTAGE_LINE |-> (!VPP_HIGH && ADDR[15:1] == 15'h0000);
	endproperty
	a_id_mode: assert property (p_id_mode) else $error("id mode");

	// Sequencer bookkeeping: retry limit, sticky fail flag, first address.
	property p_retry_max;
		s_q.retry <= 4'(otp_prog_pkg::MAX_RETRIES);
	endproperty
	a_retry_max: assert property (p_retry_max) else $error("retry over");
	property p_fail_sticky;
		(FAIL && !START) |=> FAIL;
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("fail cleared");
	property p_first_addr;
		(s_q.ph == otp_prog_pkg::ST_IDLE && START) |=> (ADDR == 16'h0000);
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("addr");
endmodule // otp_prog
`default_nettype wire

// *** core/otp_prog_pkg.sv ***
`default_nettype none
package otp_prog_pkg;
	// Clock and timing figures.
	localparam int CLK_MHZ        = 100;
	localparam int PULSE_NOM_US   = 100;
	localparam int PULSE_CYC      = PULSE_NOM_US * CLK_MHZ;
	localparam int PULSE_MIN_PCT  = 95;
	localparam int PULSE_MAX_PCT  = 105;
	localparam int SETUP_US       = 2;
	localparam int SETUP_CYC      = SETUP_US * CLK_MHZ;
	localparam int DATA_VALID_US  = 1;
	localparam int DATA_VALID_CYC = DATA_VALID_US * CLK_MHZ;
	// Algorithm figures.
	localparam int MAX_RETRIES    = 10;
	localparam int ADDR_W         = 16;
	localparam int DATA_W         = 8;
	localparam logic [3:0] RETRY_RESET = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_FIRST = 16'h0000;
	localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 16'h0000;
	localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 16'h0001;
	// Sequencer phases.
	typedef enum logic [3:0] {
		ST_IDLE, ST_RAMP, ST_PGM_SET, ST_PGM_PULSE, ST_VFY_SET,
		ST_VFY_READ, ST_RETRY_PULSE, ST_RAMP_DOWN, ST_RB_READ,
		ST_ID_READ, ST_DONE
	} phase_e;
endpackage
`default_nettype wire

// *** core/otp_src_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Source data lookup between sequencer and its reference memory.
interface otp_src_if;
	logic [15:0] addr;
	logic [7:0]  data;
	modport seq (output addr, input data);
	modport mem (input addr, output data);
endinterface
`default_nettype wire

// *** core/otp_src_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// Image of the data to be burned, loaded by the user; read data registered.
module otp_src_mem #(
	parameter int AW = 16
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	otp_src_if.mem             rd
);
	logic [7:0] mem_q [0:(1<<AW)-1];
	logic [7:0] rd_q;

	// One write port from the user, one registered read port.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		rd_q <= mem_q[rd.addr[AW-1:0]];
	end
	assign rd.data = rd_q;
endmodule // otp_src_mem
`default_nettype wire

// *** bench/otp_eprom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Four-cell one-time-programmable memory with two identification bytes.
module otp_eprom_model #(
	parameter int         PW    = 20,
	parameter int         DV    = 2,
	parameter logic [7:0] MAKER = 8'hC3, // Arbitrary value.
	parameter logic [7:0] PART  = 8'h3C  // Arbitrary value.
) (
	input  wire logic        clk,
	input  wire logic        fresh,
	input  wire logic [3:0]  need,
	input  wire logic        rb_flip,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  din,
	input  wire logic        din_oe,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        vpp_high,
	input  wire logic        vcc_prog,
	input  wire logic        id_hv,
	output logic      [7:0]  dout,
	output int               pulses,
	output int               viol
);
	logic [7:0] mem [4];
	int         cnt [4];
	int         low_cyc = 0;
	logic       ce_q    = 1'b1;
	logic       prog;
	logic [1:0] a;
	logic [15:0] a_lat;
	logic [7:0]  d_lat;
	logic        p_lat = 1'b0;

	// A cell only takes a pulse with both raised voltages and data driven.
	assign prog = vcc_prog && vpp_high && din_oe;
	assign a = addr[1:0];

	initial dout = 8'h00;

	// Pulse timing checks, cell programming and a slow, noisy readout.
	always @(posedge clk) begin
		if (fresh) begin
			foreach (mem[i]) begin
				mem[i] = 8'hFF;
				cnt[i] = 0;
			end
			pulses = 0;
			viol = 0;
			p_lat = 1'b0;
		end else begin
			if (vpp_high && !vcc_prog)
				viol++;
			if (!ce_n)
				low_cyc++;
			// Address, data and voltages are taken as the pulse starts.
			if (!ce_n && ce_q) begin
				a_lat = addr;
				d_lat = din;
				p_lat = prog;
			end
			if (ce_n && !ce_q && p_lat) begin
				if (low_cyc < PW * 95 / 100 || low_cyc > PW * 105 / 100)
					viol++;
				if (pulses == 0 && a_lat != 16'h0000)
					viol++;
				pulses++;
				cnt[a_lat[1:0]]++;
				if (cnt[a_lat[1:0]] >= need)
					mem[a_lat[1:0]] = d_lat;
			end
			if (ce_n)
				low_cyc = 0;
			ce_q = ce_n;
			// Data is only valid after the access time; otherwise it toggles.
			if (!ce_n && !din_oe && (vpp_high || !oe_n) && low_cyc >= DV)
				dout <= id_hv ? (addr[0] ? PART : MAKER) :
					(rb_flip && !vcc_prog ? ~mem[a] : mem[a]);
			else
				dout <= ~dout;
		end
	end
endmodule // otp_eprom_model
`default_nettype wire

// *** bench/otp_prog_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// Programs random images under several cell behaviours and reads the IDs.
module otp_prog_test;
	localparam logic [7:0] MAKER_ID = 8'hC3; // Arbitrary value.
	localparam logic [7:0] PART_ID  = 8'h3C; // Arbitrary value.
	localparam int          PW_CYC    = 20;
	localparam int          SU_CYC    = 4;
	localparam int          ACC_CYC   = 2;
	localparam logic [15:0] LAST_ADDR = 16'h0003;
	logic        ref_clk   = 1'b0;
	logic        rstn      = 1'b0;
	logic        start     = 1'b0;
	logic        id_start  = 1'b0;
	logic        id_sel    = 1'b0;
	logic        load_en   = 1'b0;
	logic [15:0] load_addr = 16'h0000;
	logic [7:0]  load_data = 8'h00;
	logic        fresh     = 1'b1;
	logic [3:0]  need      = 4'h1;
	logic        rb_flip   = 1'b0;
	logic [7:0]  byte_out, data_o, id_byte;
	logic [15:0] addr;
	logic        data_oe, ce_n, vpp_high, vcc_prog, id_hv, done, fail;
	logic        oe_n, busy;
	int          pulses, viol;
	int          error_cnt = 0;
	int          cmp_count = 0;
	logic [7:0]  img [4];
	int          needs [4] = '{1, 3, 11, 12};

	otp_prog #(.PULSE_CYC(PW_CYC), .SETUP_CYC(SU_CYC), .DV_CYC(ACC_CYC),
		.LAST_ADDR(LAST_ADDR)) i_otp_prog (
		.REF_CLK(ref_clk), .RSTN(rstn), .START(start),
		.ID_START(id_start), .ID_SEL(id_sel), .LOAD_EN(load_en),
		.LOAD_ADDR(load_addr), .LOAD_DATA(load_data),
		.BYTE_OUTPUTS_I(byte_out), .ADDR(addr), .DATA_O(data_o),
		.DATA_OE(data_oe), .CE_N(ce_n), .OE_N(oe_n), .VPP_HIGH(vpp_high),
		.VCC_PROG(vcc_prog), .ID_HIGH_VOLTAGE_LINE(id_hv), .BUSY(busy),
		.DONE(done), .FAIL(fail), .ID_BYTE(id_byte));

	// The model's default pulse and access counts equal PW_CYC and ACC_CYC.
	otp_eprom_model #(.MAKER(MAKER_ID), .PART(PART_ID))
		i_otp_eprom_model (
		.clk(ref_clk), .fresh(fresh), .need(need), .rb_flip(rb_flip),
		.addr(addr), .din(data_o), .din_oe(data_oe), .ce_n(ce_n),
		.oe_n(oe_n),
		.vpp_high(vpp_high), .vcc_prog(vcc_prog), .id_hv(id_hv),
		.dout(byte_out), .pulses(pulses), .viol(viol));

	initial forever #5 ref_clk = ~ref_clk;

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Waits a bounded time for the end-of-run pulse.
	task automatic wait_done;
		for (int i = 0; i < 8000; i++) begin
			@(posedge ref_clk);
			#1;
			if (done === 1'b1)
				return;
		end
		error_cnt++;
	endtask

	// One full run on a fresh part whose cells take n pulses each.
	task automatic run(input int n, input logic flip);
		@(negedge ref_clk);
		fresh = 1'b1;
		need = n[3:0];
		rb_flip = flip;
		@(negedge ref_clk);
		fresh = 1'b0;
		for (int a = 0; a < 4; a++) begin
			img[a] = 8'($urandom_range(8'hFE)); // Erased value never verifies.
			load_en = 1'b1;
			load_addr = 16'(a);
			load_data = img[a];
			@(negedge ref_clk);
		end
		load_en = 1'b0;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		chk_byte({7'h00, busy}, 8'h01);
		wait_done();
		chk_byte({7'h00, busy}, 8'h00);
		chk_cnt(pulses, n > 11 ? 14 : 4 * n);
		chk_cnt(viol, 0);
		chk_byte({7'h00, fail}, {7'h00, n > 11 || flip});
		if (n <= 11)
			for (int a = 0; a < 4; a++)
				chk_byte(i_otp_eprom_model.mem[a], img[a]);
	endtask

	task automatic id_read(input logic sel, input logic [7:0] exp);
		@(negedge ref_clk);
		id_sel = sel;
		id_start = 1'b1;
		@(negedge ref_clk);
		id_start = 1'b0;
		wait_done();
		chk_byte(id_byte, exp);
	endtask

	// Main sequence.
	initial begin
		void'($urandom(32'h0b780ab4));
		repeat (20) @(negedge ref_clk);
		rstn = 1'b1;
		foreach (needs[k])
			run(needs[k], 1'b0);
		run(1 + $urandom_range(9), 1'b0);
		run(1, 1'b1);
		id_read(1'b0, MAKER_ID);
		id_read(1'b1, PART_ID);
		// A reset in the middle of a pulse must drop every level at once.
		@(negedge ref_clk);
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		repeat (30) @(negedge ref_clk);
		rstn = 1'b0;
		@(negedge ref_clk);
		chk_byte({3'h0, ce_n, data_oe, vpp_high, vcc_prog, busy}, 8'h10);
		rstn = 1'b1;
		run(2, 1'b0);
		results();
	end

	// Cuts a hang short.
	initial begin
		#500000;
		error_cnt++;
		results();
	end
endmodule // otp_prog_test
`default_nettype wire
